// ===== logic/floppy_cmd_defs.svh
// constants for the floppy command phase decoder
`ifndef FLOPPY_CMD_DEFS_SVH
`define FLOPPY_CMD_DEFS_SVH
`define OP_VERIFY_LOW5   5'h16
`define OP_WRITE_LOW6    6'h05
`define OP_WRDEL_LOW6    6'h09
`define OP_FORMAT_MASK   8'hbf
`define OP_FORMAT_CODE   8'h0d
`define OP_VERSION       8'h10
`define OP_RECAL         8'h07
`define OP_SENSE_INT     8'h08
`define NPRM_SECTOR      4'h8
`define NPRM_FORMAT      4'h5
`define NPRM_RECAL       4'h1
`define RES_LEN_SECTOR   3'h7
`define RES_LEN_SENSE    3'h2
`define RES_LEN_ONE      3'h1
`define ST0_INVALID      8'h80
`define ST0_ABNORMAL     8'h40
`define ST0_SEEK_END     8'h20
`define ST0_EQUIP_CHECK  8'h10
`define ST1_NOT_WRITABLE 8'h02
`define ST1_DATA_ERROR   8'h20
`define BIT_MULTI_TRACK  7
`define BIT_DENSITY      6
`define BIT_SKIP         5
`define BIT_COUNT_CHECK  7
`define BIT_HEAD         2
`define SECTOR_BASE_LEN  15'h0080
`define STEP_TIME_NS     3000
`define CLK_PERIOD_NS    10
`define STEP_CYCLES      ((`STEP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MAX_STEPS        8'h50
`endif

// ===== logic/floppy_cmd_pkg.sv
// types of the floppy command phase decoder
`default_nettype none
package floppy_cmd_pkg;
  typedef enum logic [6:0] {
    ST_IDLE   = 7'h01,
    ST_PARAM  = 7'h02,
    ST_WRITE  = 7'h04,
    ST_VERIFY = 7'h08,
    ST_FORMAT = 7'h10,
    ST_RECAL  = 7'h20,
    ST_RESULT = 7'h40
  } phase_e;

  typedef struct packed {
    phase_e          state;
    logic [7:0]      cmd;
    logic [7:0][7:0] prm;
    logic [3:0]      pidx;
    logic [3:0]      nprm;
    logic            in_rdy;
    logic [6:0][7:0] res;
    logic [2:0]      ridx;
    logic [2:0]      rlen;
    logic            res_v;
    logic [7:0]      res_d;
    logic [14:0]     bcnt;
    logic [7:0]      rec;
    logic [7:0]      scnt;
    logic [3:0][7:0] present_cylinder_number;
    logic            irq;
    logic [7:0]      irq_st0;
    logic [1:0]      irq_drv;
    logic            step;
    logic            dir;
    logic [15:0]     tmr;
    logic [7:0]      steps;
    logic            vreq;
    logic [7:0]      vlast;
    logic            deleted;
    logic [1:0]      ds;
    logic            hd;
  } ctrl_s;
endpackage
`default_nettype wire

// ===== logic/byte_fifo.sv
// show-ahead fifo with registered read data
`default_nettype none
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic                       clk,
  input  wire logic                       reset_n,
  input  wire logic                       in_valid,
  input  wire logic [WIDTH-1:0]           in_data,
  output logic                            in_ready,
  output logic                            out_valid,
  output logic [WIDTH-1:0]                out_data,
  input  wire logic                       out_ready,
  output logic [$clog2(DEPTH+1)-1:0]      level
);
  localparam int AW = $clog2(DEPTH);
  localparam int LW = $clog2(DEPTH+1);
  // pointers wrap by overflow, so the depth must be a power of two
  if (DEPTH < 4 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_size_check
    $error("byte_fifo: bad WIDTH or DEPTH");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [LW-1:0]               cnt;
    logic                        ov;
    logic [WIDTH-1:0]            od;
    logic                        ir;
  } fifo_s;
  fifo_s q, d;

  // one push and one pop per cycle; read data looks ahead at the next head
  always_comb begin
    logic push;
    logic pop;
    push = in_valid && q.ir;
    pop  = q.ov && out_ready;
    d = q;
    if (push) begin
      d.mem[q.wp] = in_data;
      d.wp = q.wp + AW'(1);
    end
    if (pop) d.rp = q.rp + AW'(1);
    d.cnt = q.cnt + LW'(push) - LW'(pop);
    d.ov  = d.cnt != '0;
    d.od  = d.mem[d.rp];
    d.ir  = d.cnt != LW'(DEPTH);
  end

  always_ff @(posedge clk) begin
    if (!reset_n) q <= '0;
    else q <= d;
  end

  assign in_ready  = q.ir;
  assign out_valid = q.ov;
  assign out_data  = q.od;
  assign level     = q.cnt;
endmodule
`default_nettype wire

// ===== logic/floppy_cmd_phase_decoder.sv
// command, execution and result phases of a floppy controller
//
// Behaviour
// - verify: flags byte, drive byte with count-check bit, seven sector parameters
// - verify execution checks sectors on the medium, moves no data bytes
// - write commands: flags, drive byte, seven parameters; host bytes go to drive
// - verify and writes return three status bytes then C, H, R, N
// - recalibrate steps outward to track zero, raises interrupt, no result
// - sense interrupt status answers status byte zero first
// - sense interrupt status second byte is the present cylinder number
// - unknown command does nothing and returns one byte 80h
`include "floppy_cmd_defs.svh"
`default_nettype none
module floppy_cmd_phase_decoder #(
  parameter int          FIFO_DEPTH = 32,
  parameter logic [7:0]  VERSION_ID = 8'h5a  // arbitrary value
) (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       cmd_valid,
  input  wire logic [7:0] cmd_data,
  output logic            cmd_ready,
  output logic            res_valid,
  output logic [7:0]      res_data,
  input  wire logic       res_ready,
  output logic            wr_valid,
  output logic [7:0]      wr_data,
  input  wire logic       wr_ready,
  output logic            write_deleted,
  output logic            verify_req,
  output logic [7:0]      verify_last,
  input  wire logic       verify_done,
  input  wire logic       verify_fail,
  input  wire logic       write_protect,
  input  wire logic       track_zero,
  output logic            step,
  output logic            step_inward,
  output logic [1:0]      drive_select,
  output logic            head_select_bit,
  output logic            interrupt
);
  localparam int LW = $clog2(FIFO_DEPTH+1);
  localparam logic [15:0] STEP_CYC = 16'(`STEP_CYCLES);
  // the ready margin needs a few spare fifo slots beyond the byte in flight
  if (FIFO_DEPTH < 8) begin : g_depth_check
    $error("floppy_cmd_phase_decoder: FIFO_DEPTH too small");
  end

  floppy_cmd_pkg::ctrl_s q, d;
  logic          acc;
  logic          push;
  logic [LW-1:0] lvl;
  logic          fifo_in_ready;

  assign acc  = cmd_valid && q.in_rdy;
  assign push = acc && (q.state == floppy_cmd_pkg::ST_WRITE || q.state == floppy_cmd_pkg::ST_FORMAT);

  byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .reset_n   (reset_n),
    .in_valid  (push),
    .in_data   (cmd_data),
    .in_ready  (fifo_in_ready),
    .out_valid (wr_valid),
    .out_data  (wr_data),
    .out_ready (wr_ready),
    .level     (lvl)
  );

  // command decode, execution sequencing and result shifting
  always_comb begin
    logic [14:0] bps;
    logic [7:0]  st0;
    logic [7:0]  st1;
    logic        fin;
    bps = '0;
    st0 = '0;
    st1 = '0;
    fin = 1'b0;
    d = q;
    d.step = 1'b0;
    bps = (q.prm[4] == 8'h00) ? {7'h00, q.prm[7]} : (`SECTOR_BASE_LEN << q.prm[4][2:0]);
    st0 = {5'h00, q.hd, q.ds};
    unique case (q.state)
      floppy_cmd_pkg::ST_IDLE: if (acc) begin
        d.cmd = cmd_data;
        d.pidx = '0;
        d.state = floppy_cmd_pkg::ST_PARAM;
        d.res = '0;
        if (cmd_data[4:0] == `OP_VERIFY_LOW5) d.nprm = `NPRM_SECTOR;
        else if (cmd_data[5:0] == `OP_WRITE_LOW6 || cmd_data[5:0] == `OP_WRDEL_LOW6) d.nprm = `NPRM_SECTOR;
        else if ((cmd_data & `OP_FORMAT_MASK) == `OP_FORMAT_CODE) d.nprm = `NPRM_FORMAT;
        else if (cmd_data == `OP_RECAL) d.nprm = `NPRM_RECAL;
        else begin
          d.state = floppy_cmd_pkg::ST_RESULT;
          d.rlen = `RES_LEN_ONE;
          if (cmd_data == `OP_VERSION) d.res[0] = VERSION_ID;
          else if (cmd_data == `OP_SENSE_INT && q.irq) begin
            d.res[0] = q.irq_st0;
            d.res[1] = q.present_cylinder_number[q.irq_drv];
            d.rlen = `RES_LEN_SENSE;
            d.irq = 1'b0;
          end else d.res[0] = `ST0_INVALID;
        end
      end
      floppy_cmd_pkg::ST_PARAM: if (acc) begin
        d.prm[q.pidx[2:0]] = cmd_data;  // index stays below eight while collecting
        d.pidx = q.pidx + 4'h1;
        if (q.pidx == 4'h0) begin
          d.ds = cmd_data[1:0];
          d.hd = (q.cmd == `OP_RECAL) ? 1'b0 : cmd_data[`BIT_HEAD];
        end
        if (d.pidx == q.nprm) begin
          d.bcnt = '0;
          d.scnt = '0;
          d.rec = q.prm[3];
          d.deleted = q.cmd[3];
          if (q.cmd[4:0] == `OP_VERIFY_LOW5) begin
            d.state = floppy_cmd_pkg::ST_VERIFY;
            d.vreq = 1'b1;
            d.vlast = q.prm[0][`BIT_COUNT_CHECK] ? q.prm[3] + cmd_data - 8'h01 : q.prm[5];
          end else if (q.cmd == `OP_RECAL) begin
            d.state = floppy_cmd_pkg::ST_RECAL;
            d.tmr = '0;
            d.steps = '0;
          end else if (q.nprm == `NPRM_FORMAT) d.state = floppy_cmd_pkg::ST_FORMAT;
          else d.state = floppy_cmd_pkg::ST_WRITE;
        end
      end
      floppy_cmd_pkg::ST_WRITE: if (write_protect) fin = 1'b1;
      else if (acc) begin
        d.bcnt = q.bcnt + 15'h1;
        if (d.bcnt == bps) begin
          d.bcnt = '0;
          if (q.rec == q.prm[5]) fin = 1'b1;
          else d.rec = q.rec + 8'h01;
        end
      end
      floppy_cmd_pkg::ST_VERIFY: if (verify_done) begin
        d.vreq = 1'b0;
        d.rec = q.vlast;
        fin = 1'b1;
      end
      floppy_cmd_pkg::ST_FORMAT: if (write_protect) fin = 1'b1;
      else if (acc) begin
        d.bcnt = q.bcnt + 15'h1;
        if (q.bcnt[1:0] == 2'h3) begin
          d.scnt = q.scnt + 8'h01;
          if (d.scnt == q.prm[2]) fin = 1'b1;
        end
      end
      floppy_cmd_pkg::ST_RECAL: if (q.tmr != '0) d.tmr = q.tmr - 16'h1;
      else if (track_zero || q.steps == `MAX_STEPS) begin
        d.present_cylinder_number[q.ds] = 8'h00;
        d.irq = 1'b1;
        d.irq_drv = q.ds;
        d.irq_st0 = st0 | `ST0_SEEK_END | (track_zero ? 8'h00 : (`ST0_ABNORMAL | `ST0_EQUIP_CHECK));
        d.state = floppy_cmd_pkg::ST_IDLE;
      end else begin
        d.step = 1'b1;
        d.steps = q.steps + 8'h01;
        d.tmr = STEP_CYC - 16'h1;
      end
      floppy_cmd_pkg::ST_RESULT: if (q.res_v && res_ready) begin
        if (q.ridx == q.rlen - 3'h1) begin
          d.res_v = 1'b0;
          d.state = floppy_cmd_pkg::ST_IDLE;
        end else begin
          d.ridx = q.ridx + 3'h1;
          d.res_d = q.res[d.ridx];
        end
      end
      default: d.state = floppy_cmd_pkg::ST_IDLE;
    endcase
    // finished execution loads the seven result bytes, except that format loads only the three status bytes
    if (fin) begin
      st1 = write_protect && q.state != floppy_cmd_pkg::ST_VERIFY ? `ST1_NOT_WRITABLE : 8'h00;
      if (q.state == floppy_cmd_pkg::ST_VERIFY && verify_fail) st1 = `ST1_DATA_ERROR;
      d.res[0] = st0 | (st1 != 8'h00 ? `ST0_ABNORMAL : 8'h00);
      d.res[1] = st1;
      d.res[2] = 8'h00;
      if (q.state != floppy_cmd_pkg::ST_FORMAT) begin
        d.res[3] = q.prm[1];
        d.res[4] = q.prm[2];
        d.res[5] = d.rec;
        d.res[6] = q.prm[4];
      end
      d.rlen = `RES_LEN_SECTOR;
      d.state = floppy_cmd_pkg::ST_RESULT;
    end
    if (d.state == floppy_cmd_pkg::ST_RESULT && q.state != floppy_cmd_pkg::ST_RESULT) begin
      d.ridx = '0;
      d.res_v = 1'b1;
      d.res_d = d.res[0];
    end
    // registered ready keeps one slot spare for a byte already in flight
    d.in_rdy = d.state == floppy_cmd_pkg::ST_IDLE || d.state == floppy_cmd_pkg::ST_PARAM ||
               ((d.state == floppy_cmd_pkg::ST_WRITE || d.state == floppy_cmd_pkg::ST_FORMAT) &&
                fifo_in_ready && lvl < LW'(FIFO_DEPTH - 2) && !write_protect);
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      q <= '0;
      q.state <= floppy_cmd_pkg::ST_IDLE;
      q.in_rdy <= 1'b1;
    end else q <= d;
  end

  assign cmd_ready       = q.in_rdy;
  assign res_valid       = q.res_v;
  assign res_data        = q.res_d;
  assign write_deleted   = q.deleted;
  assign verify_req      = q.vreq;
  assign verify_last     = q.vlast;
  assign step            = q.step;
  assign step_inward     = q.dir;
  assign drive_select    = q.ds;
  assign head_select_bit = q.hd;
  assign interrupt       = q.irq;

  // checks on the phases
  sequence s_idle_take(logic [7:0] code);
    q.state == floppy_cmd_pkg::ST_IDLE && acc && cmd_data == code;
  endsequence
  sequence s_irq_sense;
    s_idle_take(`OP_SENSE_INT) ##0 q.irq;
  endsequence

  AST_VERIFY_PARAMS: assert property (@(posedge clk) disable iff (!reset_n)
    q.state == floppy_cmd_pkg::ST_IDLE && acc && cmd_data[4:0] == `OP_VERIFY_LOW5 |=> q.nprm == 4'h8)
    else $error("verify does not expect eight parameter bytes");
  AST_VERIFY_NO_DATA: assert property (@(posedge clk) disable iff (!reset_n)
    q.state == floppy_cmd_pkg::ST_VERIFY |-> !push && !q.in_rdy && q.vreq)
    else $error("data moved during verify");
  AST_WRITE_PATH: assert property (@(posedge clk) disable iff (!reset_n)
    q.state == floppy_cmd_pkg::ST_WRITE && acc && !write_protect |-> push ##1 wr_valid)
    else $error("write byte not passed to drive");
  AST_RESULT_SEVEN: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(q.state == floppy_cmd_pkg::ST_RESULT) && $past(q.state) != floppy_cmd_pkg::ST_IDLE |-> q.rlen == 3'h7)
    else $error("sector result is not seven bytes");
  AST_RECAL_OUTWARD: assert property (@(posedge clk) disable iff (!reset_n)
    q.step |-> !q.dir && $past(q.state) == floppy_cmd_pkg::ST_RECAL)
    else $error("step outside recalibrate or inward");
  AST_RECAL_END: assert property (@(posedge clk) disable iff (!reset_n)
    q.state == floppy_cmd_pkg::ST_RECAL && q.tmr == '0 && track_zero |=> q.irq && q.present_cylinder_number[q.irq_drv] == 8'h00 && !q.res_v)
    else $error("recalibrate end wrong");
  AST_SENSE_FIRST: assert property (@(posedge clk) disable iff (!reset_n)
    s_irq_sense |=> q.res_v && q.res_d == $past(q.irq_st0) && !q.irq)
    else $error("sense status byte zero wrong");
  AST_SENSE_PCN: assert property (@(posedge clk) disable iff (!reset_n)
    s_irq_sense |=> q.rlen == 3'h2 && q.res[1] == $past(q.present_cylinder_number[q.irq_drv]))
    else $error("sense cylinder byte wrong");
  AST_FORMAT_PARAMS: assert property (@(posedge clk) disable iff (!reset_n)
    q.state == floppy_cmd_pkg::ST_IDLE && acc && (cmd_data & `OP_FORMAT_MASK) == `OP_FORMAT_CODE |=> q.nprm == 4'h5)
    else $error("format parameter count wrong");
  AST_INVALID: assert property (@(posedge clk) disable iff (!reset_n)
    s_idle_take(8'hff) |=> q.res_v && q.res_d == 8'h80 && q.rlen == 3'h1 ##1 q.state != floppy_cmd_pkg::ST_PARAM)
    else $error("invalid command answer wrong");
endmodule
`default_nettype wire

// ===== tb/floppy_drive_model.sv
// behavioural floppy drive facing the decoder's drive side
`default_nettype none
module floppy_drive_model #(
  parameter int START_TRACK = 3
) (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       stall,
  input  wire logic       fail_mode,
  input  wire logic       wr_valid,
  input  wire logic [7:0] wr_data,
  output logic            wr_ready,
  input  wire logic       verify_req,
  input  wire logic [7:0] verify_last,
  output logic            verify_done,
  output logic            verify_fail,
  input  wire logic       step,
  input  wire logic       step_inward,
  output logic            track_zero
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] got[$];
  logic [7:0] seen_last;
  int         track;
  int         steps;
  int         vcnt;
  // stalls come only from the bench so the fifo can be forced to refuse
  assign wr_ready = !stall;
  assign track_zero = (track == 0);
  // fail level means something only beside done; otherwise show its inverse
  assign verify_fail = verify_done ? fail_mode : !fail_mode;
  // sector check takes a few cycles and moves no data bytes
  always @(posedge clk) begin
    verify_done <= 1'b0;
    if (!reset_n) begin
      track <= START_TRACK;
      steps <= 0;
      vcnt <= 0;
    end else begin
      if (wr_valid && wr_ready) begin
        got.push_back(wr_data);
      end
      if (!verify_req) begin
        vcnt <= 0;
      end else if (vcnt == 5) begin
        verify_done <= 1'b1;
        vcnt <= 0;
      end else begin
        vcnt <= vcnt + 1;
      end
      if (verify_req) begin
        seen_last <= verify_last;
      end
      // head moves one track out per outward pulse, stops at zero; inward pulses do not move it
      if (step) begin
        steps <= steps + 1;
        if (!step_inward && track > 0) begin
          track <= track - 1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== tb/testbench.sv
// self-checking bench for the floppy command phase decoder
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin miscompares++; $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk = 1'b0;
  logic       reset_n = 1'b0;
  logic       cmd_valid = 1'b0;
  logic [7:0] cmd_data = 8'h00;
  logic       res_ready = 1'b0;
  logic       write_protect = 1'b0;
  logic       stall = 1'b0;
  logic       fail_mode = 1'b0;
  logic       cmd_ready, res_valid, wr_valid, wr_ready, write_deleted, verify_req, verify_done;
  logic       verify_fail, track_zero, step, step_inward, head_select_bit, interrupt;
  logic [7:0] res_data, wr_data, verify_last;
  logic [1:0] drive_select;
  int         miscompares = 0;
  int         n_compared = 0;
  int         n0;
  logic [7:0] sent[$];

  floppy_cmd_phase_decoder #(.FIFO_DEPTH(32), .VERSION_ID(8'h3c)) i_floppy_cmd_phase_decoder ( // arbitrary id
    .clk, .reset_n, .cmd_valid, .cmd_data, .cmd_ready, .res_valid, .res_data, .res_ready,
    .wr_valid, .wr_data, .wr_ready, .write_deleted, .verify_req, .verify_last, .verify_done,
    .verify_fail, .write_protect, .track_zero, .step, .step_inward, .drive_select,
    .head_select_bit, .interrupt);

  floppy_drive_model #(.START_TRACK(3)) i_floppy_drive_model (
    .clk, .reset_n, .stall, .fail_mode, .wr_valid, .wr_data, .wr_ready, .verify_req,
    .verify_last, .verify_done, .verify_fail, .step, .step_inward, .track_zero);

  // 100 MHz
  always #5 clk = ~clk;

  task automatic complete_run();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // bounded wait on a flag sampled at the edge; a hang ends the run
  task automatic wait_hi(ref logic sig, input int lim);
    int n;
    n = 0;
    @(posedge clk);
    while (sig !== 1'b1) begin
      n++;
      if (n > lim) begin
        miscompares++;
        complete_run();
      end
      @(posedge clk);
    end
  endtask

  // host writes bytes; valid held until the edge that takes each one
  task automatic send(input logic [7:0] q[$]);
    foreach (q[i]) begin
      cmd_valid <= 1'b1;
      cmd_data <= q[i];
      wait_hi(cmd_ready, 3000);
    end
    cmd_valid <= 1'b0;
  endtask

  // host reads all result bytes, compares the leading ones, then expects silence
  task automatic take_res(input int total, input logic [7:0] exp[$]);
    for (int i = 0; i < total; i++) begin
      res_ready <= 1'b1;
      wait_hi(res_valid, 5000);
      if (i < exp.size()) `CHK(res_data, exp[i])
    end
    res_ready <= 1'b0;
    @(posedge clk);
    `CHK(res_valid, 1'b0)
  endtask

  initial begin
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    send('{8'h10});
    take_res(1, '{8'h3c});
    send('{8'h00});
    take_res(1, '{8'h80});
    send('{8'hff});
    take_res(1, '{8'h80});
    send('{8'h08});
    take_res(1, '{8'h80});
    // recalibrate drive 1 from track 3
    send('{8'h07, 8'h01});
    wait_hi(interrupt, 3000);
    `CHK(i_floppy_drive_model.steps, 3)
    `CHK(res_valid, 1'b0)
    `CHK(drive_select, 2'h1)
    `CHK(step_inward, 1'b0)
    send('{8'h08});
    take_res(2, '{8'h21, 8'h00});
    `CHK(interrupt, 1'b0)
    // write two 20-byte sectors while the drive stalls; the fifo must refuse
    for (int i = 0; i < 40; i++) sent.push_back(8'h5c ^ i[7:0]);
    stall <= 1'b1;
    fork
      send({8'h45, 8'h05, 8'h02, 8'h01, 8'h03, 8'h00, 8'h04, 8'h1b, 8'h14, sent});
      begin
        repeat (150) @(posedge clk);
        `CHK(cmd_ready, 1'b0)
        `CHK(i_floppy_drive_model.got.size(), 0)
        stall <= 1'b0;
      end
    join
    take_res(7, '{8'h05, 8'h00, 8'h00, 8'h02, 8'h01, 8'h04, 8'h00});
    repeat (40) @(posedge clk);
    `CHK(i_floppy_drive_model.got.size(), 40)
    foreach (sent[i]) `CHK(i_floppy_drive_model.got[i], sent[i])
    `CHK(head_select_bit, 1'b1)
    `CHK(write_deleted, 1'b0)
    // deleted-data write on a protected disk aborts
    write_protect <= 1'b1;
    send('{8'h09, 8'h02, 8'h01, 8'h00, 8'h01, 8'h00, 8'h01, 8'h1b, 8'h04});
    take_res(7, '{8'h42, 8'h02});
    `CHK(write_deleted, 1'b1)
    write_protect <= 1'b0;
    // verify with count check and passing, then without and failing
    for (int k = 0; k < 2; k++) begin
      fail_mode <= k[0];
      n0 = i_floppy_drive_model.got.size();
      send('{8'h56, {~k[0], 7'h03}, 8'h05, 8'h00, 8'h02, 8'h01, 8'h08, 8'h1b, 8'h03});
      if (k == 0) take_res(7, '{8'h03, 8'h00, 8'h00, 8'h05, 8'h00, 8'h04, 8'h01});
      else take_res(7, '{8'h43, 8'h20});
      `CHK(i_floppy_drive_model.seen_last, (k == 0) ? 8'h04 : 8'h08)
      `CHK(i_floppy_drive_model.got.size(), n0)
      `CHK(verify_req, 1'b0)
    end
    // format two sectors on drive 1; the eight id bytes reach the drive
    send('{8'h4d, 8'h01, 8'h02, 8'h02, 8'h54, 8'he5, 8'h00, 8'h00, 8'h01, 8'h02, 8'h00, 8'h00, 8'h02, 8'h02});
    take_res(7, '{8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
    `CHK(i_floppy_drive_model.got.size(), 48)
    complete_run();
  end
endmodule
`default_nettype wire
